/* rtl/cls_params.svh */
`ifndef CLS_PARAMS_SVH
`define CLS_PARAMS_SVH

// Register byte offsets on the APB side
`define CLS_OFF_CTRL 12'h000
`define CLS_OFF_STATUS 12'h004
`define CLS_OFF_INT_STAT 12'h008
`define CLS_OFF_INT_MASK 12'h00c
`define CLS_OFF_FLAGS 12'h010
`define CLS_OFF_GPR_BASE 12'h020

// Control register fields
`define CLS_CTRL_ALIGN_BIT 0
`define CLS_CTRL_CP_BIT 1
`define CLS_RST_CTRL 2'h0

// Event bits, shared by status and mask
`define CLS_EV_ALIGN 0
`define CLS_EV_ABORT 1
`define CLS_EV_UNDEF 2
`define CLS_EV_DONE 3
`define CLS_EV_W 4
`define CLS_RST_MASK 4'h0

// Status register fields
`define CLS_STAT_BUSY_BIT 0
`define CLS_STAT_FLAGS_LSB 4

// Opcode patterns
`define CLS_OPC_LBU_IMM 5'h0f
`define CLS_OPC_LHU_IMM 5'h11
`define CLS_OPC_SHL_IMM 5'h00
`define CLS_OPC_LBU_REG 7'h2e
`define CLS_OPC_LHU_REG 7'h2d
`define CLS_OPC_LBS_REG 7'h2b
`define CLS_OPC_LHS_REG 7'h2f

`endif

/* rtl/cls_pkg.sv */
`default_nettype none
package cls_pkg;

  // Decoded operation kinds
  typedef enum logic [2:0] {
    CLS_OP_NONE = 3'h0,
    CLS_OP_LBU_IMM = 3'h1,
    CLS_OP_LBU_REG = 3'h2,
    CLS_OP_LHU_IMM = 3'h3,
    CLS_OP_LHU_REG = 3'h4,
    CLS_OP_LBS_REG = 3'h5,
    CLS_OP_LHS_REG = 3'h6,
    CLS_OP_SHL_IMM = 3'h7
  } cls_op_t;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    CLS_ST_IDLE = 2'b01,
    CLS_ST_MEM = 2'b10
  } cls_state_t;

endpackage
`default_nettype wire

/* rtl/cls_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cls_params.svh"

module cls_decode (
  input wire logic [15:0] instr,
  input wire logic [31:0] src_val,
  input wire logic c_in,
  output cls_pkg::cls_op_t op,
  output logic [2:0] dst_sel,
  output logic [2:0] base_sel,
  output logic [2:0] off_sel,
  output logic [4:0] imm5,
  output logic [31:0] shift_res,
  output logic shift_c
);

  // One extra bit catches the last bit shifted out
  logic [32:0] wide;

  // Opcode match; five-bit groups first, then the seven-bit group
  always_comb
  begin
    op = cls_pkg::CLS_OP_NONE;
    if (instr[15:11] == `CLS_OPC_LBU_IMM)
      op = cls_pkg::CLS_OP_LBU_IMM;
    else if (instr[15:11] == `CLS_OPC_LHU_IMM)
      op = cls_pkg::CLS_OP_LHU_IMM;
    else if (instr[15:11] == `CLS_OPC_SHL_IMM)
      op = cls_pkg::CLS_OP_SHL_IMM;
    else
    begin
      // Register-offset loads share the field layout below
      unique case (instr[15:9])
        `CLS_OPC_LBU_REG: op = cls_pkg::CLS_OP_LBU_REG;
        `CLS_OPC_LHU_REG: op = cls_pkg::CLS_OP_LHU_REG;
        `CLS_OPC_LBS_REG: op = cls_pkg::CLS_OP_LBS_REG;
        `CLS_OPC_LHS_REG: op = cls_pkg::CLS_OP_LHS_REG;
        default: op = cls_pkg::CLS_OP_NONE;
      endcase
    end
  end

  // Fixed field positions
  assign dst_sel = instr[2:0];
  assign base_sel = instr[5:3];
  assign off_sel = instr[8:6];
  assign imm5 = instr[10:6];

  // Zero fill from the right; bit 32 is source bit 32-n
  assign wide = {1'b0, src_val} << imm5;
  assign shift_res = wide[31:0];
  // Zero amount leaves carry alone
  assign shift_c = (imm5 == 5'h00) ? c_in : wide[32];

endmodule // cls_decode
`default_nettype wire

/* rtl/cls_core.sv */
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cls_params.svh"

module cls_core #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [15:0] instr,
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic mem_half,
  input wire logic mem_ack,
  input wire logic mem_abort,
  input wire logic [31:0] mem_rdata,
  output logic retire,
  output logic exc_align,
  output logic exc_abort,
  output logic exc_undef,
  output logic irq
);

  // Load kind tests, used by decode and checks
  function automatic logic op_is_load(cls_pkg::cls_op_t op);
    return (op != cls_pkg::CLS_OP_NONE) && (op != cls_pkg::CLS_OP_SHL_IMM);
  endfunction

  function automatic logic op_is_half(cls_pkg::cls_op_t op);
    return (op == cls_pkg::CLS_OP_LHU_IMM) || (op == cls_pkg::CLS_OP_LHU_REG)
      || (op == cls_pkg::CLS_OP_LHS_REG);
  endfunction

  // Extend returned data by size and signedness
  function automatic logic [31:0] ld_extend(logic [31:0] d, cls_pkg::cls_op_t op);
    unique case (op)
      cls_pkg::CLS_OP_LBS_REG: return {{24{d[7]}}, d[7:0]};
      cls_pkg::CLS_OP_LHS_REG: return {{16{d[15]}}, d[15:0]};
      cls_pkg::CLS_OP_LHU_IMM, cls_pkg::CLS_OP_LHU_REG:
        return {16'h0000, d[15:0]};
      default: return {24'h000000, d[7:0]};
    endcase
  endfunction

  cls_pkg::cls_state_t state_ff; // Sequencer
  logic [31:0] gpr_ff [8]; // Low register file
  logic flag_n_ff, flag_z_ff, flag_c_ff, flag_v_ff; // Condition flags
  logic ctrl_align_ff; // Alignment checking enabled
  logic ctrl_cp_ff; // Control coprocessor present
  logic [`CLS_EV_W-1:0] int_stat_ff; // Sticky events
  logic [`CLS_EV_W-1:0] int_mask_ff; // Interrupt enables
  cls_pkg::cls_op_t op_ff; // Load in flight
  logic [2:0] dst_ff; // Its destination
  logic mem_req_ff, mem_half_ff;
  logic [31:0] mem_addr_ff;
  logic [31:0] prdata_ff;
  logic busy_d_ff; // Core was busy last cycle
  logic retire_ff, exc_align_ff, exc_abort_ff, exc_undef_ff;

  cls_pkg::cls_op_t dec_op;
  logic [2:0] dec_dst, dec_base, dec_off;
  logic [4:0] dec_imm5;
  logic [31:0] shift_res;
  logic shift_c;
  logic [31:0] base_val, off_val, ld_off, ld_addr, ld_ext;
  logic acc, align_fault, ld_go, shl_go, ld_done, ld_ok;
  logic apb_wr, gpr_hit, addr_bad;
  logic [31:0] rd_mux;
  logic [`CLS_EV_W-1:0] ev;

  // Field split and shifter; shift source sits where the base does
  cls_decode u_dec (
    .instr(instr),
    .src_val(base_val),
    .c_in(flag_c_ff),
    .op(dec_op),
    .dst_sel(dec_dst),
    .base_sel(dec_base),
    .off_sel(dec_off),
    .imm5(dec_imm5),
    .shift_res(shift_res),
    .shift_c(shift_c)
  );

  assign base_val = gpr_ff[dec_base];
  assign off_val = gpr_ff[dec_off];

  // APB and instructions are serialised so reads never see half a writeback
  assign instr_ready = (state_ff == cls_pkg::CLS_ST_IDLE) && !psel;
  assign acc = instr_valid && instr_ready;

  // Address: byte offset unscaled, half offset doubled, else register
  always_comb
  begin
    unique case (dec_op)
      cls_pkg::CLS_OP_LBU_IMM: ld_off = {27'h0, dec_imm5};
      cls_pkg::CLS_OP_LHU_IMM: ld_off = {26'h0, dec_imm5, 1'b0};
      default: ld_off = off_val;
    endcase
  end
  assign ld_addr = base_val + ld_off;

  // Odd half address faults only with checking present and enabled
  assign align_fault = acc && op_is_half(dec_op) && ld_addr[0]
    && ctrl_align_ff && ctrl_cp_ff;
  assign ld_go = acc && op_is_load(dec_op) && !align_fault;
  assign shl_go = acc && (dec_op == cls_pkg::CLS_OP_SHL_IMM);
  assign ld_done = (state_ff == cls_pkg::CLS_ST_MEM) && mem_ack;
  assign ld_ok = ld_done && !mem_abort;
  assign ld_ext = ld_extend(mem_rdata, op_ff);

  // Sequencer and memory request; request holds until acknowledged
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_ff <= cls_pkg::CLS_ST_IDLE;
      mem_req_ff <= 1'b0;
      mem_addr_ff <= 32'h00000000;
      mem_half_ff <= 1'b0;
      op_ff <= cls_pkg::CLS_OP_NONE;
      dst_ff <= 3'h0;
    end
    else
    begin
      unique case (state_ff)
        cls_pkg::CLS_ST_IDLE:
          if (ld_go)
          begin
            state_ff <= cls_pkg::CLS_ST_MEM;
            mem_req_ff <= 1'b1;
            mem_addr_ff <= ld_addr;
            mem_half_ff <= op_is_half(dec_op);
            op_ff <= dec_op;
            dst_ff <= dec_dst;
          end
        cls_pkg::CLS_ST_MEM:
          if (mem_ack)
          begin
            state_ff <= cls_pkg::CLS_ST_IDLE;
            mem_req_ff <= 1'b0;
          end
        // Illegal code recovers to idle
        default:
        begin
          state_ff <= cls_pkg::CLS_ST_IDLE;
          mem_req_ff <= 1'b0;
        end
      endcase
    end
  end

  // Register file; execution writes beat APB, which is stalled anyway
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 8; i++)
        gpr_ff[i] <= 32'h00000000;
    end
    else if (shl_go)
      gpr_ff[dec_dst] <= shift_res;
    else if (ld_ok)
      gpr_ff[dst_ff] <= ld_ext;
    else if (apb_wr && gpr_hit)
      gpr_ff[paddr[4:2]] <= pwdata;
  end

  // Flags: shift sets N, Z, C; V is never touched by execution
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      flag_n_ff <= 1'b0;
      flag_z_ff <= 1'b0;
      flag_c_ff <= 1'b0;
      flag_v_ff <= 1'b0;
    end
    else if (shl_go)
    begin
      flag_n_ff <= shift_res[31];
      flag_z_ff <= (shift_res == 32'h00000000);
      flag_c_ff <= shift_c;
    end
    else if (apb_wr && (paddr == ADDR_W'(`CLS_OFF_FLAGS)))
      {flag_n_ff, flag_z_ff, flag_c_ff, flag_v_ff} <= pwdata[3:0];
  end

  // Event pulses, one cycle after their cause
  assign ev[`CLS_EV_ALIGN] = align_fault;
  assign ev[`CLS_EV_ABORT] = ld_done && mem_abort;
  assign ev[`CLS_EV_UNDEF] = acc && (dec_op == cls_pkg::CLS_OP_NONE);
  assign ev[`CLS_EV_DONE] = shl_go || ld_ok;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      retire_ff <= 1'b0;
      exc_align_ff <= 1'b0;
      exc_abort_ff <= 1'b0;
      exc_undef_ff <= 1'b0;
      busy_d_ff <= 1'b0;
    end
    else
    begin
      retire_ff <= ev[`CLS_EV_DONE];
      exc_align_ff <= ev[`CLS_EV_ALIGN];
      exc_abort_ff <= ev[`CLS_EV_ABORT];
      exc_undef_ff <= ev[`CLS_EV_UNDEF];
      busy_d_ff <= (state_ff != cls_pkg::CLS_ST_IDLE) || acc;
    end
  end

  // APB slave: no wait state unless the core is or just was busy
  assign pready = (state_ff == cls_pkg::CLS_ST_IDLE) && !busy_d_ff;
  assign apb_wr = psel && penable && pwrite && pready;
  assign gpr_hit = (paddr[ADDR_W-1:5] == (ADDR_W-5)'(`CLS_OFF_GPR_BASE >> 5))
    && (paddr[1:0] == 2'h0);

  // Read decode; unmapped reads zero and errors
  always_comb
  begin
    rd_mux = 32'h00000000;
    addr_bad = 1'b0;
    unique case (paddr)
      ADDR_W'(`CLS_OFF_CTRL): rd_mux = {30'h0, ctrl_cp_ff, ctrl_align_ff};
      ADDR_W'(`CLS_OFF_STATUS):
        rd_mux = {24'h0, flag_n_ff, flag_z_ff, flag_c_ff, flag_v_ff, 3'h0,
          state_ff == cls_pkg::CLS_ST_MEM};
      ADDR_W'(`CLS_OFF_INT_STAT): rd_mux = {28'h0, int_stat_ff};
      ADDR_W'(`CLS_OFF_INT_MASK): rd_mux = {28'h0, int_mask_ff};
      ADDR_W'(`CLS_OFF_FLAGS):
        rd_mux = {28'h0, flag_n_ff, flag_z_ff, flag_c_ff, flag_v_ff};
      default:
      begin
        rd_mux = gpr_hit ? gpr_ff[paddr[4:2]] : 32'h00000000;
        addr_bad = !gpr_hit;
      end
    endcase
  end
  assign pslverr = psel && penable && pready && addr_bad;

  // Read data tracks the addressed register while selected for a read
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      prdata_ff <= 32'h00000000;
    else if (psel && !pwrite)
      prdata_ff <= rd_mux;
  end

  // Control, mask and sticky status; a new event wins over its clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      {ctrl_cp_ff, ctrl_align_ff} <= `CLS_RST_CTRL;
      int_mask_ff <= `CLS_RST_MASK;
      int_stat_ff <= '0;
    end
    else
    begin
      if (apb_wr && (paddr == ADDR_W'(`CLS_OFF_CTRL)))
      begin
        ctrl_align_ff <= pwdata[`CLS_CTRL_ALIGN_BIT];
        ctrl_cp_ff <= pwdata[`CLS_CTRL_CP_BIT];
      end
      if (apb_wr && (paddr == ADDR_W'(`CLS_OFF_INT_MASK)))
        int_mask_ff <= pwdata[`CLS_EV_W-1:0];
      if (apb_wr && (paddr == ADDR_W'(`CLS_OFF_INT_STAT)))
        int_stat_ff <= (int_stat_ff & ~pwdata[`CLS_EV_W-1:0]) | ev;
      else
        int_stat_ff <= int_stat_ff | ev;
    end
  end

  assign irq = |(int_stat_ff & int_mask_ff);
  assign prdata = prdata_ff;
  assign mem_req = mem_req_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_half = mem_half_ff;
  assign retire = retire_ff;
  assign exc_align = exc_align_ff;
  assign exc_abort = exc_abort_ff;
  assign exc_undef = exc_undef_ff;

  // Checking helpers
  logic [31:0] dst_cur;
  logic c_expect;
  assign dst_cur = gpr_ff[dst_ff];
  assign c_expect = base_val[5'(6'd32 - {1'b0, dec_imm5})];

  property p_lbu_imm;
    @(posedge clock) disable iff (!rst_n)
    (acc && dec_op == cls_pkg::CLS_OP_LBU_IMM) |=> (mem_req && !mem_half
      && mem_addr == $past(base_val) + {27'h0, $past(dec_imm5)});
  endproperty
  a_lbu_imm: assert property (p_lbu_imm) else $error("byte imm address wrong");

  property p_lhu_imm;
    @(posedge clock) disable iff (!rst_n)
    (acc && dec_op == cls_pkg::CLS_OP_LHU_IMM && !align_fault) |=> (mem_req
      && mem_half && mem_addr == $past(base_val) + {26'h0, $past(dec_imm5), 1'b0});
  endproperty
  a_lhu_imm: assert property (p_lhu_imm) else $error("half imm address wrong");

  property p_align;
    @(posedge clock) disable iff (!rst_n)
    (acc && op_is_half(dec_op) && ld_addr[0] && ctrl_align_ff && ctrl_cp_ff)
      |=> (exc_align && !mem_req) ##1 (!exc_align || $past(align_fault));
  endproperty
  a_align: assert property (p_align) else $error("alignment fault missed");

  property p_reg_addr;
    @(posedge clock) disable iff (!rst_n)
    (ld_go && dec_op != cls_pkg::CLS_OP_LBU_IMM && dec_op != cls_pkg::CLS_OP_LHU_IMM)
      |=> (mem_addr == $past(base_val) + $past(off_val));
  endproperty
  a_reg_addr: assert property (p_reg_addr) else $error("register address wrong");

  // Expected halfword rebuilt from the bus data, not from the extend function
  property p_ext;
    @(posedge clock) disable iff (!rst_n)
    ld_ok |=> retire && (!$past(mem_half) || gpr_ff[$past(dst_ff)]
      == {{16{$past(op_ff) == cls_pkg::CLS_OP_LHS_REG && $past(mem_rdata[15])}},
      $past(mem_rdata[15:0])});
  endproperty
  a_ext: assert property (p_ext) else $error("load writeback wrong");

  property p_ubyte;
    @(posedge clock) disable iff (!rst_n)
    (ld_ok && !mem_half && op_ff != cls_pkg::CLS_OP_LBS_REG)
      |=> gpr_ff[$past(dst_ff)] == {24'h000000, $past(mem_rdata[7:0])};
  endproperty
  a_ubyte: assert property (p_ubyte) else $error("unsigned byte wrong");

  property p_sbyte;
    @(posedge clock) disable iff (!rst_n)
    (ld_ok && op_ff == cls_pkg::CLS_OP_LBS_REG)
      |=> gpr_ff[$past(dst_ff)] == {{24{$past(mem_rdata[7])}}, $past(mem_rdata[7:0])};
  endproperty
  a_sbyte: assert property (p_sbyte) else $error("signed byte wrong");

  property p_abort;
    @(posedge clock) disable iff (!rst_n)
    (ld_done && mem_abort) |=> exc_abort && !retire
      && gpr_ff[$past(dst_ff)] == $past(dst_cur);
  endproperty
  a_abort: assert property (p_abort) else $error("abort changed destination");

  property p_shift;
    @(posedge clock) disable iff (!rst_n)
    shl_go |=> gpr_ff[$past(dec_dst)] == ($past(base_val) << $past(dec_imm5))
      && flag_v_ff == $past(flag_v_ff) && flag_n_ff == gpr_ff[$past(dec_dst)][31]
      && flag_z_ff == (gpr_ff[$past(dec_dst)] == 32'h00000000);
  endproperty
  a_shift: assert property (p_shift) else $error("shift result or flags wrong");

  property p_carry;
    @(posedge clock) disable iff (!rst_n)
    shl_go |=> flag_c_ff == (($past(dec_imm5) == 5'h00) ? $past(flag_c_ff)
      : $past(c_expect));
  endproperty
  a_carry: assert property (p_carry) else $error("shift carry wrong");

  c_shift: cover property (@(posedge clock) disable iff (!rst_n) shl_go ##1 retire);
  c_load: cover property (@(posedge clock) disable iff (!rst_n) ld_go ##[1:20] ld_ok);
  c_abort: cover property (@(posedge clock) disable iff (!rst_n) ld_done && mem_abort);
  c_fault: cover property (@(posedge clock) disable iff (!rst_n) align_fault);

endmodule // cls_core
`default_nettype wire

/* verif/cls_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Data memory stand-in: answers each load after a set delay
module cls_mem_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] delay,
  input wire logic abort_en,
  output logic mem_ack,
  output logic mem_abort,
  output logic [31:0] mem_rdata
);
  logic [3:0] wait_ff; // Cycles the open request has waited

  // One answer per request; between answers the lines wander
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wait_ff <= 4'h0;
      mem_ack <= 1'b0;
      mem_abort <= 1'b0;
      mem_rdata <= 32'h0;
    end
    else if (mem_req && !mem_ack && wait_ff == delay)
    begin
      mem_ack <= 1'b1;
      mem_abort <= abort_en;
      // Junk upper half so a missing extension shows
      mem_rdata <= {16'hbeef, mem_addr[7:0] ^ 8'h3c, mem_addr[7:0] ^ 8'h80};
      wait_ff <= 4'h0;
    end
    else
    begin
      // Released abort and data lines never hold the last value; ack drops low
      mem_ack <= 1'b0;
      mem_abort <= ~mem_abort;
      mem_rdata <= ~mem_rdata;
      wait_ff <= (mem_req && !mem_ack) ? wait_ff + 4'h1 : 4'h0;
    end
  end
endmodule // cls_mem_model

`default_nettype wire

/* verif/compact_load_shift_exec_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cls_params.svh"

module compact_load_shift_exec_test;
  // One table row: operands in, result, flags and load address out
  typedef struct packed {
    logic [15:0] instr;
    logic [31:0] base;
    logic [31:0] off;
    logic [31:0] res;
    logic [3:0] flags;
    logic [31:0] addr;
  } cls_row_t;

  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic instr_valid = 1'b0;
  logic [15:0] instr = 16'h0;
  logic [3:0] delay = 4'h0;
  logic abort_en = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic instr_ready;
  wire logic mem_req;
  wire logic [31:0] mem_addr;
  wire logic mem_half;
  wire logic mem_ack;
  wire logic mem_abort;
  wire logic [31:0] mem_rdata;
  wire logic retire;
  wire logic exc_align;
  wire logic exc_abort;
  wire logic exc_undef;
  wire logic irq;
  int num_errors = 0;
  int tests_run = 0;
  int acks = 0; // Loads answered so far
  logic [31:0] rd; // Last APB read data
  logic err; // Last APB error
  logic [3:0] ev; // Completion: undef, abort, align, retire
  logic [31:0] seen_addr = 32'h0; // Address of last answered load
  logic seen_half = 1'b0; // Size of last answered load
  // Base r3, offset r4, destination r5; flags start at C and V set
  cls_row_t rows [12] = '{
    '{16'h795d, 32'h10000010, 32'h0, 32'h00000095, 4'h3, 32'h10000015},
    '{16'h7fdd, 32'h200000e0, 32'h0, 32'h0000007f, 4'h3, 32'h200000ff},
    '{16'h5d1d, 32'h100, 32'h23, 32'h000000a3, 4'h3, 32'h123},
    '{16'h88dd, 32'h40, 32'h0, 32'h00007ac6, 4'h3, 32'h46},
    '{16'h5b1d, 32'h200, 32'h0e, 32'h0000328e, 4'h3, 32'h20e},
    '{16'h571d, 32'h300, 32'h01, 32'hffffff81, 4'h3, 32'h301},
    '{16'h571d, 32'h300, 32'h90, 32'h00000010, 4'h3, 32'h390},
    '{16'h5f1d, 32'h400, 32'hc4, 32'hfffff844, 4'h3, 32'h4c4},
    '{16'h001d, 32'h80000001, 32'h0, 32'h80000001, 4'hb, 32'h0},
    '{16'h005d, 32'h40000000, 32'h0, 32'h80000000, 4'h9, 32'h0},
    '{16'h011d, 32'hf0000000, 32'h0, 32'h00000000, 4'h7, 32'h0},
    '{16'h07dd, 32'h00000001, 32'h0, 32'h80000000, 4'h9, 32'h0}
  };

  cls_core i_cls_core (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr(instr), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_half(mem_half), .mem_ack(mem_ack), .mem_abort(mem_abort),
    .mem_rdata(mem_rdata), .retire(retire), .exc_align(exc_align),
    .exc_abort(exc_abort), .exc_undef(exc_undef), .irq(irq)
  );

  cls_mem_model i_cls_mem_model (
    .clock(clock), .rst_n(rst_n), .mem_req(mem_req), .mem_addr(mem_addr),
    .delay(delay), .abort_en(abort_en), .mem_ack(mem_ack),
    .mem_abort(mem_abort), .mem_rdata(mem_rdata)
  );

  // 40 MHz clock
  always #12.5 clock = ~clock;

  // Note each answered load and its address
  always @(posedge clock)
  begin
    if (mem_req && mem_ack)
    begin
      seen_addr <= mem_addr;
      seen_half <= mem_half;
      acks <= acks + 1;
    end
  end

  task automatic end_of_test;
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A wait that ran out ends the run
  task automatic hang;
    num_errors++;
    end_of_test();
  endtask

  // One APB transfer; request held until pready seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Sampled at the rising edge, before the design's own updates land
    @(posedge clock);
    while (pready !== 1'b1 && n < 100)
    begin
      @(posedge clock);
      n++;
    end
    if (pready !== 1'b1)
      hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Offer one instruction, then wait for its completion pulse
  task automatic run(input logic [15:0] op);
    int n;
    n = 0;
    @(posedge clock);
    instr_valid <= 1'b1;
    instr <= op;
    // Taken at the rising edge that sees ready high; dropped right there
    @(posedge clock);
    while (instr_ready !== 1'b1 && n < 100)
    begin
      @(posedge clock);
      n++;
    end
    instr_valid <= 1'b0;
    ev = 4'h0;
    while (ev === 4'h0 && n < 100)
    begin
      @(negedge clock);
      ev = {exc_undef, exc_abort, exc_align, retire};
      n++;
    end
    if (ev === 4'h0)
      hang();
  endtask

  // Operands in r3 and r4, a marker in r5, flags C and V set
  task automatic prep(input logic [31:0] b, input logic [31:0] o);
    apb(1'b1, `CLS_OFF_GPR_BASE + 12'h00c, b);
    apb(1'b1, `CLS_OFF_GPR_BASE + 12'h010, o);
    apb(1'b1, `CLS_OFF_GPR_BASE + 12'h014, 32'ha5a5a5a5);
    apb(1'b1, `CLS_OFF_FLAGS, 32'h3);
  endtask

  // Check destination and flags after an instruction
  task automatic result(input logic [31:0] r, input logic [31:0] f);
    apb(1'b0, `CLS_OFF_GPR_BASE + 12'h014, 32'h0);
    check(rd, r);
    apb(1'b0, `CLS_OFF_FLAGS, 32'h0);
    check(rd, f);
  endtask

  task automatic chk_irq(input logic e);
    @(negedge clock);
    check({31'h0, irq}, {31'h0, e});
  endtask

  initial
  begin
    int a0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, `CLS_OFF_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `CLS_OFF_INT_MASK, 32'h0);
    check(rd, 32'h0);
    chk_irq(1'b0);
    delay <= 4'h3;
    // Table of loads and shifts, slow memory
    foreach (rows[i])
    begin
      prep(rows[i].base, rows[i].off);
      run(rows[i].instr);
      check(ev, 32'h1);
      result(rows[i].res, rows[i].flags);
      if (rows[i].addr != 32'h0)
        check(seen_addr, rows[i].addr);
    end
    // Odd halfword address with checking on: fault, no access
    delay <= 4'h0;
    apb(1'b1, `CLS_OFF_CTRL, 32'h3);
    prep(32'h101, 32'h0);
    a0 = acks;
    run(16'h5b1d);
    check(ev, 32'h2);
    check(acks, a0);
    result(32'ha5a5a5a5, 32'h3);
    // Coprocessor absent: the access goes out
    apb(1'b1, `CLS_OFF_CTRL, 32'h1);
    run(16'h5b1d);
    check(ev, 32'h1);
    check(acks, a0 + 1);
    check(seen_addr, 32'h101);
    check({31'h0, seen_half}, 32'h1);
    // Data abort leaves the destination alone
    abort_en <= 1'b1;
    prep(32'h100, 32'h5);
    run(16'h5d1d);
    check(ev, 32'h4);
    check(seen_addr, 32'h105);
    check({31'h0, seen_half}, 32'h0);
    result(32'ha5a5a5a5, 32'h3);
    abort_en <= 1'b0;
    // Outside the group: flagged only
    run(16'hffff);
    check(ev, 32'h8);
    apb(1'b0, `CLS_OFF_INT_STAT, 32'h0);
    check(rd, 32'hf);
    apb(1'b1, `CLS_OFF_INT_STAT, 32'hf);
    apb(1'b0, `CLS_OFF_INT_STAT, 32'h0);
    check(rd, 32'h0);
    // Done event masked in, raised, cleared, then masked out
    apb(1'b1, `CLS_OFF_INT_MASK, 32'h8);
    run(16'h001d);
    chk_irq(1'b1);
    apb(1'b1, `CLS_OFF_INT_STAT, 32'h8);
    chk_irq(1'b0);
    apb(1'b1, `CLS_OFF_INT_MASK, 32'h0);
    run(16'h001d);
    chk_irq(1'b0);
    apb(1'b0, `CLS_OFF_INT_STAT, 32'h0);
    check(rd, 32'h8);
    // Unmapped address is refused and reads zero
    apb(1'b0, 12'h040, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // Flags seen through status, then a reset in mid-run clears them and the events
    apb(1'b0, `CLS_OFF_STATUS, 32'h0);
    check(rd, 32'h30);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, `CLS_OFF_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `CLS_OFF_INT_STAT, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `CLS_OFF_GPR_BASE + 12'h014, 32'h0);
    check(rd, 32'h0);
    end_of_test();
  end
endmodule // compact_load_shift_exec_test

`default_nettype wire
